// ===== design/llcb_pkg.sv
package llcb_pkg;
   // register addresses on the serial register port
   localparam logic [7:0] LLCB_PROT_ADDR = 8'h94;
   localparam logic [7:0] LLCB_DRIVE_ADDR = 8'h95;
   localparam logic [15:0] LLCB_PROT_RST = 16'h0000;
   localparam logic [15:0] LLCB_DRIVE_RST = 16'h0000;
   // protection_limit_config field positions
   localparam int LLCB_OT_HI = 15;
   localparam int LLCB_OT_LO = 14;
   localparam int LLCB_CL_STALL_BIT = 13;
   localparam int LLCB_OL_STALL_BIT = 12;
   localparam int LLCB_NOMOTOR_BIT = 11;
   localparam int LLCB_KT_BIT = 10;
   localparam int LLCB_SPEED_BIT = 9;
   localparam int LLCB_OC_BIT = 8;
   localparam int LLCB_ACC_HI = 7;
   localparam int LLCB_ACC_LO = 4;
   localparam int LLCB_LCK_HI = 3;
   localparam int LLCB_LCK_LO = 1;
   localparam int LLCB_RANGE_BIT = 0;
   // drive_behaviour_config field positions
   localparam int LLCB_SPDIN_BIT = 15;
   localparam int LLCB_FREQ_BIT = 14;
   localparam int LLCB_KTW_HI = 13;
   localparam int LLCB_KTW_LO = 12;
   localparam int LLCB_IND_BIT = 11;
   localparam int LLCB_MECH_BIT = 10;
   localparam int LLCB_MTGT_BIT = 9;
   localparam int LLCB_REL_BIT = 8;
   localparam int LLCB_OPEN_BIT = 7;
   localparam int LLCB_RAMP_HI = 6;
   localparam int LLCB_RAMP_LO = 4;
   localparam int LLCB_DUTY_HI = 3;
   localparam int LLCB_DUTY_LO = 2;
   localparam int LLCB_SLEW_HI = 1;
   localparam int LLCB_SLEW_LO = 0;
   // current limits in units of 100 mA; zero means no limit
   localparam logic [7:0] LLCB_NO_LIMIT = 8'h00;
   localparam logic [7:0] LLCB_OT_1A0 = 8'h0A;
   localparam logic [7:0] LLCB_OT_1A6 = 8'h10;
   localparam logic [7:0] LLCB_OT_2A0 = 8'h14;
   localparam logic [7:0] LLCB_ACC_STEP = 8'h02;
   localparam logic [7:0] LLCB_R1_2A5 = 8'h19;
   localparam logic [7:0] LLCB_R1_1A9 = 8'h13;
   localparam logic [7:0] LLCB_R1_1A5 = 8'h0F;
   localparam logic [7:0] LLCB_R1_0A9 = 8'h09;
   localparam logic [7:0] LLCB_R2_STEP = 8'h04;
   // chopping frequency in kHz
   localparam logic [7:0] LLCB_CHOP_LOW_KHZ = 8'h19;
   localparam logic [7:0] LLCB_CHOP_HIGH_KHZ = 8'h32;
   typedef enum logic [1:0] {
      LLCB_OT_OFF = 2'b00,
      LLCB_OT_1A = 2'b01,
      LLCB_OT_16A = 2'b10,
      LLCB_OT_2A = 2'b11
   } llcb_ot_type;
endpackage

// ===== design/llcb_limit_decode.sv
`timescale 1ns/1ps
// turns raw field codes into limits in 100 mA units
module llcb_limit_decode
   import llcb_pkg::*;
(
   input wire logic [1:0] ot_sel_i,
   input wire logic [3:0] accel_code_i,
   input wire logic [2:0] lock_code_i,
   input wire logic range_sel_i,
   output logic [7:0] ot_limit_o,
   output logic [7:0] accel_limit_o,
   output logic [7:0] lock_limit_o
);

   function automatic logic [7:0] llcb_scale(input logic [3:0] code, input logic [7:0] step);
      llcb_scale = 8'(code * step);
   endfunction

   always_comb begin
      case (llcb_ot_type'(ot_sel_i))
         LLCB_OT_1A: ot_limit_o = LLCB_OT_1A0;
         LLCB_OT_16A: ot_limit_o = LLCB_OT_1A6;
         LLCB_OT_2A: ot_limit_o = LLCB_OT_2A0;
         default: ot_limit_o = accel_limit_o;
      endcase
   end

   // code 0 scales to zero, which already means no limit
   assign accel_limit_o = llcb_scale(accel_code_i, LLCB_ACC_STEP);

   always_comb begin
      if (range_sel_i) begin
         lock_limit_o = llcb_scale({1'b0, lock_code_i} + 4'h1, LLCB_R2_STEP);
      end else begin
         case (lock_code_i[1:0])
            2'b00: lock_limit_o = LLCB_R1_2A5;
            2'b01: lock_limit_o = LLCB_R1_1A9;
            2'b10: lock_limit_o = LLCB_R1_1A5;
            default: lock_limit_o = LLCB_R1_0A9;
         endcase
      end
   end
endmodule

// ===== design/llcb_bank.sv
`timescale 1ns/1ps
// What this block does
// - overheat clamp: off, 1 A, 1.6 A, 2 A
// - bit 13 enables closed-loop stall detect
// - bit 12 enables open-loop stall detect
// - bit 11 gates missing-motor fault entirely
// - bit 10 enables torque-constant fault
// - bit 9 enables abnormal speed fault
// - bit 8 enables overcurrent lock fault
// - accel limit is code times 0.2 A
// - range one: four limits, top bit ignored
// - range two: 0.4 A to 3.2 A steps
// - bit 0 picks lock limit range
// - protection register 0x94, resets zero, RW
// - drive register 0x95, resets zero, RW
// - speed input analog or PWM select
// - chopping frequency 25 or 50 kHz
module llcb_bank
   import llcb_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   // register port from the serial slave, same clock domain
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   output logic [15:0] reg_rdata_o,
   output logic reg_rvalid_o,
   output logic reg_hit_o,
   // raw fault requests from the detectors, same clock domain
   input wire logic cl_stall_raw_i,
   input wire logic ol_stall_raw_i,
   input wire logic no_motor_raw_i,
   input wire logic kt_fault_raw_i,
   input wire logic speed_fault_raw_i,
   input wire logic phase_over_lock_i,
   input wire logic overheat_warn_i,
   output logic lock_fault_o,
   output logic no_motor_fault_o,
   output logic [7:0] active_limit_o,
   output logic [7:0] lock_limit_o,
   // drive settings, straight from the register
   output logic speed_input_type_o,
   output logic [7:0] chop_freq_khz_o,
   output logic [1:0] torque_const_window_o,
   output logic inductive_surge_guard_en_o,
   output logic mechanical_surge_guard_en_o,
   output logic mechanical_surge_target_o,
   output logic position_probe_release_mode_o,
   output logic stay_open_loop_o,
   output logic [2:0] closed_loop_ramp_o,
   output logic [1:0] min_duty_policy_o,
   output logic [1:0] phase_edge_speed_o
);

   logic [15:0] protection_limit_config_r;
   logic [15:0] drive_behaviour_config_r;
   logic [7:0] ot_limit;
   logic [7:0] accel_limit;
   logic [7:0] lock_limit;
   logic lock_any;

   ////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         protection_limit_config_r <= LLCB_PROT_RST;
      end else if (clk_en_i && reg_wr_i && reg_addr_i == LLCB_PROT_ADDR) begin
         protection_limit_config_r <= reg_wdata_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         drive_behaviour_config_r <= LLCB_DRIVE_RST;
      end else if (clk_en_i && reg_wr_i && reg_addr_i == LLCB_DRIVE_ADDR) begin
         drive_behaviour_config_r <= reg_wdata_i;
      end
   end

   // read answers one cycle later; unmapped addresses read zero with hit low
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 16'h0000;
         reg_rvalid_o <= 1'b0;
         reg_hit_o <= 1'b0;
      end else if (clk_en_i) begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i && reg_addr_i == LLCB_PROT_ADDR) begin
            reg_rdata_o <= protection_limit_config_r;
            reg_hit_o <= 1'b1;
         end else if (reg_rd_i && reg_addr_i == LLCB_DRIVE_ADDR) begin
            reg_rdata_o <= drive_behaviour_config_r;
            reg_hit_o <= 1'b1;
         end else begin
            reg_rdata_o <= 16'h0000;
            reg_hit_o <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // limit decode
   llcb_limit_decode u_decode (
      .ot_sel_i(protection_limit_config_r[LLCB_OT_HI:LLCB_OT_LO]),
      .accel_code_i(protection_limit_config_r[LLCB_ACC_HI:LLCB_ACC_LO]),
      .lock_code_i(protection_limit_config_r[LLCB_LCK_HI:LLCB_LCK_LO]),
      .range_sel_i(protection_limit_config_r[LLCB_RANGE_BIT]),
      .ot_limit_o(ot_limit),
      .accel_limit_o(accel_limit),
      .lock_limit_o(lock_limit)
   );

   ////////////////////////////////////////////////////////////////////////
   // fault gating; outputs registered, so one cycle after the raw request
   assign lock_any =
      (cl_stall_raw_i && protection_limit_config_r[LLCB_CL_STALL_BIT]) ||
      (ol_stall_raw_i && protection_limit_config_r[LLCB_OL_STALL_BIT]) ||
      (kt_fault_raw_i && protection_limit_config_r[LLCB_KT_BIT]) ||
      (speed_fault_raw_i && protection_limit_config_r[LLCB_SPEED_BIT]) ||
      (phase_over_lock_i && protection_limit_config_r[LLCB_OC_BIT]);

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         lock_fault_o <= 1'b0;
         no_motor_fault_o <= 1'b0;
         active_limit_o <= LLCB_NO_LIMIT;
         lock_limit_o <= LLCB_NO_LIMIT;
      end else if (clk_en_i) begin
         lock_fault_o <= lock_any;
         // cleared enable means this fault is never reported
         no_motor_fault_o <= no_motor_raw_i
                             && protection_limit_config_r[LLCB_NOMOTOR_BIT];
         // outside a warning the acceleration threshold governs
         active_limit_o <= overheat_warn_i ? ot_limit : accel_limit;
         // the threshold only matters when its lock fault is enabled
         lock_limit_o <= protection_limit_config_r[LLCB_OC_BIT] ? lock_limit
                                                                 : LLCB_NO_LIMIT;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // drive settings
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         speed_input_type_o <= 1'b0;
         chop_freq_khz_o <= LLCB_CHOP_LOW_KHZ;
         torque_const_window_o <= 2'h0;
         inductive_surge_guard_en_o <= 1'b0;
         mechanical_surge_guard_en_o <= 1'b0;
         mechanical_surge_target_o <= 1'b0;
         position_probe_release_mode_o <= 1'b0;
         stay_open_loop_o <= 1'b0;
         closed_loop_ramp_o <= 3'h0;
         min_duty_policy_o <= 2'h0;
         phase_edge_speed_o <= 2'h0;
      end else if (clk_en_i) begin
         speed_input_type_o <= drive_behaviour_config_r[LLCB_SPDIN_BIT];
         chop_freq_khz_o <= drive_behaviour_config_r[LLCB_FREQ_BIT] ? LLCB_CHOP_HIGH_KHZ
                                                                   : LLCB_CHOP_LOW_KHZ;
         torque_const_window_o <= drive_behaviour_config_r[LLCB_KTW_HI:LLCB_KTW_LO];
         inductive_surge_guard_en_o <= drive_behaviour_config_r[LLCB_IND_BIT];
         mechanical_surge_guard_en_o <= drive_behaviour_config_r[LLCB_MECH_BIT];
         mechanical_surge_target_o <= drive_behaviour_config_r[LLCB_MTGT_BIT];
         position_probe_release_mode_o <= drive_behaviour_config_r[LLCB_REL_BIT];
         stay_open_loop_o <= drive_behaviour_config_r[LLCB_OPEN_BIT];
         closed_loop_ramp_o <= drive_behaviour_config_r[LLCB_RAMP_HI:LLCB_RAMP_LO];
         min_duty_policy_o <= drive_behaviour_config_r[LLCB_DUTY_HI:LLCB_DUTY_LO];
         phase_edge_speed_o <= drive_behaviour_config_r[LLCB_SLEW_HI:LLCB_SLEW_LO];
      end
   end
endmodule

// ===== verification/llcb_bank_chk.sv
`timescale 1ns/1ps
module llcb_bank_chk
   import llcb_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   input wire logic reg_hit_o,
   input wire logic no_motor_raw_i,
   input wire logic no_motor_fault_o,
   input wire logic [7:0] lock_limit_o,
   input wire logic speed_input_type_o,
   input wire logic [7:0] chop_freq_khz_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   wire rd = reg_rd_i && clk_en_i;
   wire wr = reg_wr_i && clk_en_i;
   wire map = reg_addr_i inside {LLCB_PROT_ADDR, LLCB_DRIVE_ADDR};
   // quiet cycles after the write so both output latencies have landed
   sequence drive_wr;
      wr && reg_addr_i == LLCB_DRIVE_ADDR ##1 (clk_en_i && !reg_wr_i) [*2];
   endsequence
   a_read_answer: assert property (rd |=> reg_rvalid_o)
      else $error("read not answered");
   a_unmapped_zero: assert property (rd && !map |=>
      !reg_hit_o && reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
   a_mapped_hit: assert property (rd && map |=> reg_hit_o)
      else $error("mapped read missed");
   a_prot_readback: assert property (wr && reg_addr_i == LLCB_PROT_ADDR ##1 !wr ##1
      rd && !reg_wr_i && reg_addr_i == LLCB_PROT_ADDR |=> reg_rdata_o == $past(reg_wdata_i, 3))
      else $error("readback differs");
   a_speed_copy: assert property (drive_wr |=>
      speed_input_type_o == $past(reg_wdata_i[15], 3)) else $error("speed type wrong");
   a_chop_copy: assert property (drive_wr |=> chop_freq_khz_o ==
      ($past(reg_wdata_i[14], 3) ? 8'h32 : 8'h19)) else $error("chop freq wrong");
   a_reset_clear: assert property ($rose(rst_n_i) |-> lock_limit_o == 8'h00 &&
      !no_motor_fault_o && chop_freq_khz_o == 8'h19) else $error("reset state wrong");
   a_nomotor_cause: assert property (no_motor_fault_o && $past(clk_en_i) |->
      $past(no_motor_raw_i)) else $error("no motor without cause");
   a_lock_codes: assert property (
      lock_limit_o inside {8'h00, 8'h19, 8'h13, 8'h0F, 8'h09} ||
      lock_limit_o[1:0] == 2'b00 && lock_limit_o <= 8'h20) else $error("lock limit illegal");
endmodule
bind llcb_bank llcb_bank_chk llcb_bank_chk_inst (.*);

// ===== verification/llcb_host.sv
`timescale 1ns/1ps
// host side of the register port: one whole word per call
module llcb_host (
   input wire logic clk_i,
   output logic wr_o,
   output logic rd_o,
   output logic [7:0] addr_o,
   output logic [15:0] wdata_o,
   input wire logic [15:0] rdata_i,
   input wire logic hit_i
);
   initial begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 16'h0000;
   end
   // released lines show the inverse so stale values never pass as valid
   task automatic write(input logic [7:0] a, input logic [15:0] d);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(posedge clk_i);
      #1;
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
      // idle edge so a following call never drives a line twice in one step
      @(posedge clk_i);
      #1;
   endtask
   task automatic read(input logic [7:0] a, output logic [15:0] d, output logic h);
      addr_o = a;
      rd_o = 1'b1;
      @(posedge clk_i);
      #1;
      rd_o = 1'b0;
      addr_o = ~a;
      d = rdata_i;
      h = hit_i;
      @(posedge clk_i);
      #1;
   endtask
endmodule

// ===== verification/lock_limit_config_bank_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
   $display("ERROR %s exp %h got %h", n, e, g); miscompares++; end end
module lock_limit_config_bank_bench
   import llcb_pkg::*;
;
   typedef struct packed {logic [15:0] w; logic warn; logic [7:0] act;
      logic [7:0] lck;} llcb_row_type;
   llcb_row_type rows [8] = '{
      '{16'h4130, 1'b1, 8'h0A, 8'h19}, '{16'h4130, 1'b0, 8'h06, 8'h19},
      '{16'h81FA, 1'b1, 8'h10, 8'h13}, '{16'hC10C, 1'b1, 8'h14, 8'h0F},
      '{16'h0116, 1'b1, 8'h02, 8'h09}, '{16'h010F, 1'b0, 8'h00, 8'h20},
      '{16'h0101, 1'b0, 8'h00, 8'h04}, '{16'h00FF, 1'b0, 8'h1E, 8'h00}};
   logic [15:0] pats [2] = '{16'hC000, 16'h3FFF};
   logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, warn = 1'b0;
   logic wr, rd, rvalid, hit, lock_f, nm_f, spd, ind, mech, tgt, rel, opn, h;
   logic [5:0] raw = 6'h00;
   logic [7:0] addr, act, lck, chop;
   logic [15:0] wd, rdata, d;
   logic [2:0] ramp;
   logic [1:0] tw, duty, slew;
   logic [14:0] drv;
   int miscompares = 0, n_compared = 0, cycles = 0;
   always #2 clk = ~clk;
   assign drv = {spd, tw, ind, mech, tgt, rel, opn, ramp, duty, slew};
   llcb_bank llcb_bank_inst (.sys_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(en), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata),
      .reg_rvalid_o(rvalid), .reg_hit_o(hit), .cl_stall_raw_i(raw[5]), .ol_stall_raw_i(raw[4]),
      .no_motor_raw_i(raw[3]), .kt_fault_raw_i(raw[2]), .speed_fault_raw_i(raw[1]),
      .phase_over_lock_i(raw[0]), .overheat_warn_i(warn), .lock_fault_o(lock_f),
      .no_motor_fault_o(nm_f), .active_limit_o(act), .lock_limit_o(lck),
      .speed_input_type_o(spd), .chop_freq_khz_o(chop), .torque_const_window_o(tw),
      .inductive_surge_guard_en_o(ind), .mechanical_surge_guard_en_o(mech),
      .mechanical_surge_target_o(tgt), .position_probe_release_mode_o(rel),
      .stay_open_loop_o(opn), .closed_loop_ramp_o(ramp), .min_duty_policy_o(duty),
      .phase_edge_speed_o(slew));
   llcb_host llcb_host_inst (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wd),
      .rdata_i(rdata), .hit_i(hit));
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic summarize();
      if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // the whole run is about 120 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles > 2000) begin
         miscompares++;
         summarize();
      end
   end
   initial begin
      tick(10);
      rst_n = 1'b1;
      llcb_host_inst.read(LLCB_PROT_ADDR, d, h);
      `CHK("prot rst", 16'h0000, d)
      llcb_host_inst.read(LLCB_DRIVE_ADDR, d, h);
      `CHK("drive rst", 16'h0000, d)
      `CHK("lock rst", 8'h00, lck)
      foreach (rows[i]) begin
         llcb_host_inst.write(LLCB_PROT_ADDR, rows[i].w);
         warn = rows[i].warn;
         llcb_host_inst.read(LLCB_PROT_ADDR, d, h);
         `CHK("prot rd", rows[i].w, d)
         tick(2);
         `CHK("active", rows[i].act, act)
         `CHK("lock", rows[i].lck, lck)
      end
      foreach (pats[i]) begin
         llcb_host_inst.write(LLCB_DRIVE_ADDR, pats[i]);
         tick(2);
         `CHK("drive", {pats[i][15], pats[i][13:0]}, drv)
         `CHK("chop", (pats[i][14] ? 8'h32 : 8'h19), chop)
      end
      // one enable at a time: matching cause fires, all other causes stay masked
      for (int k = 8; k < 14; k++) begin
         llcb_host_inst.write(LLCB_PROT_ADDR, 16'h0001 << k);
         raw = 6'h01 << (k - 8);
         tick(2);
         `CHK("lock on", (k != 11), lock_f)
         `CHK("nm on", (k == 11), nm_f)
         raw = ~raw;
         tick(2);
         `CHK("lock off", 1'b0, lock_f)
         `CHK("nm off", 1'b0, nm_f)
      end
      llcb_host_inst.write(8'h96, 16'hFFFF);
      llcb_host_inst.read(8'h96, d, h);
      `CHK("unmapped", 17'h00000, {h, d})
      llcb_host_inst.read(LLCB_PROT_ADDR, d, h);
      `CHK("prot kept", 17'h12000, {h, d})
      en = 1'b0;
      llcb_host_inst.write(LLCB_DRIVE_ADDR, 16'h1234);
      en = 1'b1;
      llcb_host_inst.read(LLCB_DRIVE_ADDR, d, h);
      `CHK("frozen", 16'h3FFF, d)
      rst_n = 1'b0;
      tick(1);
      rst_n = 1'b1;
      llcb_host_inst.read(LLCB_PROT_ADDR, d, h);
      `CHK("prot rst2", 16'h0000, d)
      `CHK("chop rst2", 8'h19, chop)
      summarize();
   end
endmodule
